// ---- built_in_self_test_defs.svh ----
/*
 * Constants of the serial link self-test checker: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from any design file.
 */
`ifndef BUILT_IN_SELF_TEST_DEFS_SVH
`define BUILT_IN_SELF_TEST_DEFS_SVH

// ****************************************************************
// Register offsets (plain register port, printed offsets)
// ****************************************************************
`define OFS_CONFIG 8'h01
`define OFS_IRQ_STATUS 8'h02
`define OFS_IRQ_MASK 8'h03
`define OFS_LINK_DETECT 8'h0c
`define OFS_FWD_ERROR 8'h25

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_TEST_EN_BIT 0
`define CFG_OSC_SEL_BIT 1
`define LINK_DETECT_BIT 0
`define EV_START_BIT 0
`define EV_ERROR_BIT 1
`define EV_DONE_BIT 2

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CONFIG_RESET 8'h00
`define IRQ_MASK_RESET 3'h0
`define OSC_FREQ_MHZ 33
`define CLK_FREQ_MHZ 200
// One ref_clk cycle stands for the half pixel period low pulse
`define PASS_LOW_CYCLES 4'h1
`endif

// ---- built_in_self_test_pkg.sv ----
/*
 * Types shared by the self-test checker modules.
 * Assumes built_in_self_test_defs.svh holds the numeric constants.
 */
package built_in_self_test_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [34:0] payload_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAKE,
        ST_WAIT_LOCK,
        ST_CHECK,
        ST_DONE
    } test_state_t;
endpackage

// ---- rx_check_if.sv ----
/*
 * Interface carrying received frames to the payload checker and its
 * verdict back to the controller.
 * Assumes one clock domain, ref_clk.
 */
`timescale 1ns/1ps
interface rx_check_if;
    import built_in_self_test_pkg::*;
    logic frame_valid;
    payload_t payload;
    logic check_en;
    logic frame_err;
    modport ctrl (output frame_valid, output payload, output check_en, input frame_err);
    modport chk (input frame_valid, input payload, input check_en, output frame_err);
endinterface

// ---- sync_2ff.sv ----
/*
 * Two flip-flop synchroniser for level inputs from pins.
 * Assumes the inputs are quasi-static against ref_clk.
 */
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("sync_2ff width must be at least one");
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- payload_checker.sv ----
/*
 * Compares each received frame payload with all zeros and flags a
 * frame holding one or more wrong bits.
 * Assumes the receiver has already descrambled the stream.
 */
`timescale 1ns/1ps
module payload_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    rx_check_if.chk chk
);
    import built_in_self_test_pkg::*;

    // One flag per frame, not per bit, so an observer counts frames
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chk.frame_err <= 1'b0;
        end
        else if (clk_en)
        begin
            chk.frame_err <= chk.check_en && chk.frame_valid && (|chk.payload);
        end
    end
endmodule

// ---- serial_link_built_in_self_test_checker.sv ----
/*
 * Deserializer side self-test controller for the serial video link:
 * requests the test over the back channel, checks payloads, reports
 * errors live and holds the verdict on the pass/fail output.
 * Assumes rx_* and remote_* inputs come from logic on ref_clk, and
 * the enable and clock-select pins arrive asynchronously.
 */
// Contract
// - Test mode by pin or config bit
// - Oscillator chosen by pin or config bit
// - Send test enable over back channel
// - Wake remote serializer before test begins
// - On both-in-test and lock, pass high
// - Errored frame pulses pass low briefly
// - Dropping enable ends test and checking
// - After test pass shows error verdict
// - Verdict held until new test or reset
// - Lock status stays valid during test
// - Forward errors recorded at offset 0x25
`timescale 1ns/1ps
`include "built_in_self_test_defs.svh"
module serial_link_built_in_self_test_checker #(
    parameter int PASS_LOW = `PASS_LOW_CYCLES,
    parameter int ERR_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic self_test_enable_pin,
    input wire logic self_test_clock_select_pin,
    input wire logic rx_lock,
    input wire logic rx_frame_valid,
    input wire built_in_self_test_pkg::payload_t rx_payload,
    input wire logic remote_awake,
    input wire logic remote_in_test,
    input wire logic bc_link_detect,
    input wire built_in_self_test_pkg::reg_addr_t reg_addr,
    input wire built_in_self_test_pkg::reg_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output built_in_self_test_pkg::reg_data_t reg_rdata,
    output logic pass_fail,
    output logic lock_status,
    output logic bc_test_enable,
    output logic bc_wake,
    output logic osc_select,
    output logic test_active,
    output logic irq
);
    import built_in_self_test_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial
    begin
        if (PASS_LOW < 1 || PASS_LOW > 15)
            $error("PASS_LOW must lie in 1..15");
        if (ERR_WIDTH < 1 || ERR_WIDTH > 8)
            $error("ERR_WIDTH must lie in 1..8");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [3:0] PASS_LOW_Q = 4'(PASS_LOW);
    localparam logic [ERR_WIDTH-1:0] ERR_MAX = '1;

    logic [1:0] pins_sync;
    logic pin_enable;
    logic pin_osc;
    reg_data_t config_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [2:0] events;
    test_state_t state_q;
    test_state_t state_d;
    logic test_req;
    logic [ERR_WIDTH-1:0] err_count_q;
    logic any_err_q;
    logic [3:0] low_count_q;
    logic start_ev;
    logic done_ev;
    logic wr_status;
    logic wr_mask;
    logic wr_config;

    rx_check_if chk_bus ();

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Pins are asynchronous to ref_clk
    sync_2ff #(
        .WIDTH(2)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .async_in({self_test_clock_select_pin, self_test_enable_pin}),
        .sync_out(pins_sync)
    );

    assign pin_enable = pins_sync[0];
    assign pin_osc = pins_sync[1];

    // Either source starts the test
    assign test_req = pin_enable || config_q[`CFG_TEST_EN_BIT];

    // ****************************************************************
    // Payload checker
    // ****************************************************************
    assign chk_bus.frame_valid = rx_frame_valid;
    assign chk_bus.payload = rx_payload;
    // Checking runs only while locked inside the test
    assign chk_bus.check_en = (state_q == ST_CHECK) && rx_lock && test_req;

    payload_checker u_checker (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .chk(chk_bus)
    );

    // ****************************************************************
    // Test sequencer
    // ****************************************************************
    // Next state of the test flow
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE, ST_DONE:
                if (test_req)
                    state_d = remote_awake ? ST_WAIT_LOCK : ST_WAKE;
            ST_WAKE:
                if (!test_req)
                    state_d = ST_DONE;
                else if (remote_awake)
                    state_d = ST_WAIT_LOCK;
            ST_WAIT_LOCK:
                if (!test_req)
                    state_d = ST_DONE;
                else if (remote_in_test && rx_lock)
                    state_d = ST_CHECK;
            ST_CHECK:
                if (!test_req)
                    state_d = ST_DONE;
        endcase
    end

    assign start_ev = test_req && (state_q == ST_IDLE || state_q == ST_DONE);
    assign done_ev = !test_req && (state_q inside {ST_WAKE, ST_WAIT_LOCK, ST_CHECK});

    // State register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= ST_IDLE;
        else if (clk_en)
            state_q <= state_d;
    end

    // Test active flag and back-channel request
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bc_test_enable <= 1'b0;
            test_active <= 1'b0;
        end
        else if (clk_en)
        begin
            bc_test_enable <= (state_d != ST_IDLE) && (state_d != ST_DONE);
            test_active <= (state_d == ST_CHECK);
        end
    end

    // Wake pulse for a sleeping remote, one cycle on test entry
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bc_wake <= 1'b0;
        end
        else if (clk_en)
        begin
            bc_wake <= start_ev && !remote_awake;
        end
    end

    // Clock source choice, pin or register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            osc_select <= 1'b0;
        else if (clk_en)
            osc_select <= pin_osc || config_q[`CFG_OSC_SEL_BIT];
    end

    // Lock follows the receiver at all times, test or not
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_status <= 1'b0;
        else if (clk_en)
            lock_status <= rx_lock;
    end

    // ****************************************************************
    // Error record
    // ****************************************************************
    // Saturating count, cleared on each new test
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            err_count_q <= '0;
            any_err_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_ev)
            begin
                err_count_q <= '0;
                any_err_q <= 1'b0;
            end
            else if (chk_bus.frame_err)
            begin
                any_err_q <= 1'b1;
                if (err_count_q != ERR_MAX)
                    err_count_q <= err_count_q + 1'b1;
            end
        end
    end

    // Low pulse length counter for live error report
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_count_q <= 4'h0;
        end
        else if (clk_en)
        begin
            if (chk_bus.frame_err && state_q == ST_CHECK)
                low_count_q <= PASS_LOW_Q;
            else if (low_count_q != 4'h0)
                low_count_q <= low_count_q - 4'h1;
        end
    end

    // ****************************************************************
    // Pass/fail output
    // ****************************************************************
    // Held verdict needs no storage beyond the error flag
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pass_fail <= 1'b1;
        end
        else if (clk_en)
        begin
            unique case (state_d)
                // Error pulse taken from the checker directly
                ST_CHECK: pass_fail <= !(chk_bus.frame_err || low_count_q > 4'h1);
                ST_DONE: pass_fail <= !(any_err_q || chk_bus.frame_err);
                ST_IDLE: pass_fail <= 1'b1;
                default: pass_fail <= 1'b1;
            endcase
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    assign wr_config = reg_wr && (reg_addr == `OFS_CONFIG);
    assign wr_status = reg_wr && (reg_addr == `OFS_IRQ_STATUS);
    assign wr_mask = reg_wr && (reg_addr == `OFS_IRQ_MASK);

    // Configuration and mask registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            config_q <= `CONFIG_RESET;
            irq_mask_q <= `IRQ_MASK_RESET;
        end
        else if (clk_en)
        begin
            if (wr_config)
                config_q <= reg_wdata & 8'h03;
            if (wr_mask)
                irq_mask_q <= reg_wdata[2:0];
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `OFS_CONFIG: reg_rdata <= config_q;
                    `OFS_IRQ_STATUS: reg_rdata <= {5'h00, irq_status_q};
                    `OFS_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_q};
                    `OFS_LINK_DETECT: reg_rdata <= {7'h00, bc_link_detect};
                    `OFS_FWD_ERROR: reg_rdata <= 8'(err_count_q);
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign events[`EV_START_BIT] = start_ev;
    assign events[`EV_ERROR_BIT] = chk_bus.frame_err;
    assign events[`EV_DONE_BIT] = done_ev;

    // Sticky status; a new event beats a write-one clear
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status_q <= 3'h0;
        end
        else if (clk_en)
        begin
            irq_status_q <= (irq_status_q & ~(wr_status ? reg_wdata[2:0] : 3'h0)) | events;
        end
    end

    // Level interrupt, registered so it leaves from a flop
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end
endmodule

// ---- serial_link_built_in_self_test_checker_chk.sv ----
/* Concurrent checks on the self-test controller top ports.
   Assumes a bind into serial_link_built_in_self_test_checker on one clock, ref_clk. */
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module serial_link_built_in_self_test_checker_chk
    import built_in_self_test_pkg::*;
#(
    parameter int PASS_LOW = 1,
    parameter int ERR_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic self_test_enable_pin,
    input wire logic self_test_clock_select_pin,
    input wire logic rx_lock,
    input wire logic rx_frame_valid,
    input wire built_in_self_test_pkg::payload_t rx_payload,
    input wire logic remote_awake,
    input wire logic remote_in_test,
    input wire logic bc_link_detect,
    input wire built_in_self_test_pkg::reg_addr_t reg_addr,
    input wire built_in_self_test_pkg::reg_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire built_in_self_test_pkg::reg_data_t reg_rdata,
    input wire logic pass_fail,
    input wire logic lock_status,
    input wire logic bc_test_enable,
    input wire logic bc_wake,
    input wire logic osc_select,
    input wire logic test_active,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Errored frame taken while checking, then its short low pulse
    sequence err_frame;
        rx_frame_valid && test_active && rx_lock && (rx_payload != '0);
    endsequence
    sequence low_pulse;
        !pass_fail ##PASS_LOW (pass_fail || !test_active);
    endsequence

    a_err_pulse: assert property (err_frame |-> ##2 low_pulse)
        else $error("errored frame gave no low pulse");
    a_start_pass: assert property ($rose(test_active) |-> pass_fail
        && $past(remote_in_test && rx_lock)) else $error("checking began wrongly");
    a_enable_req: assert property (self_test_enable_pin [*5] |-> bc_test_enable)
        else $error("pin did not request the test");
    a_osc_pin: assert property (self_test_clock_select_pin [*5] |-> osc_select)
        else $error("clock select pin ignored");
    a_wake_once: assert property (bc_wake |-> bc_test_enable ##1 !bc_wake)
        else $error("wake not a single pulse with request");
    a_drop_ends: assert property ($fell(bc_test_enable) |-> ##[0:1] !test_active)
        else $error("checking went on after drop");
    // Verdict may only move while a test is requested
    a_verdict_held: assert property (!bc_test_enable && $past(!bc_test_enable)
        |-> $stable(pass_fail)) else $error("held verdict changed");
    a_lock_track: assert property ($past(clk_en) |-> lock_status == $past(rx_lock))
        else $error("lock status lost track");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule

bind serial_link_built_in_self_test_checker serial_link_built_in_self_test_checker_chk #(
    .PASS_LOW(PASS_LOW), .ERR_WIDTH(ERR_WIDTH)) chk_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .self_test_enable_pin(self_test_enable_pin),
    .self_test_clock_select_pin(self_test_clock_select_pin),
    .rx_lock(rx_lock), .rx_frame_valid(rx_frame_valid), .rx_payload(rx_payload),
    .remote_awake(remote_awake), .remote_in_test(remote_in_test),
    .bc_link_detect(bc_link_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pass_fail(pass_fail),
    .lock_status(lock_status), .bc_test_enable(bc_test_enable), .bc_wake(bc_wake),
    .osc_select(osc_select), .test_active(test_active), .irq(irq));

// ---- remote_serializer_model.sv ----
/* Behavioural far-end serializer: wakes, enters test, sends frames.
   Assumes the bench queues errored payloads through send_err. */
`timescale 1ns/1ps
// ****************************************************************
// Remote serializer model
// ****************************************************************
module remote_serializer_model
    import built_in_self_test_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bc_test_enable,
    input wire logic bc_wake,
    input wire logic slow,
    output logic remote_awake,
    output logic remote_in_test,
    output logic rx_lock,
    output logic rx_frame_valid,
    output built_in_self_test_pkg::payload_t rx_payload,
    output logic bc_link_detect
);
    payload_t pend_q;
    logic [7:0] wait_q;
    logic [7:0] cnt_q;
    logic [7:0] crc_err_q;

    // Next test frame carries these wrong bits, once
    task send_err(input payload_t m);
        pend_q = m;
    endtask

    // One process: the model is small and its steps tightly ordered
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {remote_awake, remote_in_test, rx_lock, rx_frame_valid, bc_link_detect} <= '0;
            {wait_q, cnt_q, crc_err_q} <= '0;
            rx_payload <= '0;
            pend_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            if (bc_wake)
                wait_q <= slow ? 8'd40 : 8'd3;
            else if (wait_q != 8'h00)
                wait_q <= wait_q - 8'h01;
            if (wait_q == 8'h01)
                remote_awake <= 1'b1;
            remote_in_test <= remote_awake && bc_test_enable;
            // CRC tally restarts on test entry; no CRC faults injected
            if (bc_test_enable && !remote_in_test)
                crc_err_q <= 8'h00;
            rx_lock <= remote_awake;
            bc_link_detect <= remote_awake;
            rx_frame_valid <= remote_awake && cnt_q[2:0] == 3'h0;
            // Outside test frames the lines carry a moving pattern
            if (remote_in_test && cnt_q[2:0] == 3'h0)
            begin
                rx_payload <= pend_q;
                pend_q <= '0;
            end
            else
                rx_payload <= {cnt_q, 27'h5a5a5a5};
        end
    end
endmodule

// ---- serial_link_built_in_self_test_checker_test.sv ----
/* Self-checking bench for the self-test controller.
   Assumes the remote model and the bound checker compile alongside. */
`timescale 1ns/1ps
`include "built_in_self_test_defs.svh"
// ****************************************************************
// Bench
// ****************************************************************
module serial_link_built_in_self_test_checker_test;
    import built_in_self_test_pkg::*;
    logic ref_clk, arst_n, clk_en, en_pin, cs_pin, slow, reg_wr, reg_rd, pf_q;
    logic rx_lock, rx_frame_valid, remote_awake, remote_in_test, bc_link_detect;
    logic pass_fail, lock_status, bc_test_enable, bc_wake, osc_select, test_active, irq;
    payload_t rx_payload, m;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata, reg_rdata;
    logic [15:0] lfsr_q;
    int failures = 0;
    int compares = 0;
    int pulses = 0;
    int wakes = 0;

    serial_link_built_in_self_test_checker #(.PASS_LOW(1), .ERR_WIDTH(8)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .self_test_enable_pin(en_pin), .self_test_clock_select_pin(cs_pin),
        .rx_lock(rx_lock), .rx_frame_valid(rx_frame_valid), .rx_payload(rx_payload),
        .remote_awake(remote_awake), .remote_in_test(remote_in_test),
        .bc_link_detect(bc_link_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pass_fail(pass_fail),
        .lock_status(lock_status), .bc_test_enable(bc_test_enable), .bc_wake(bc_wake),
        .osc_select(osc_select), .test_active(test_active), .irq(irq));
    // Board straps lie outside this block and are taken as set
    remote_serializer_model remote (
        .ref_clk(ref_clk), .arst_n(arst_n), .bc_test_enable(bc_test_enable),
        .bc_wake(bc_wake), .slow(slow), .remote_awake(remote_awake),
        .remote_in_test(remote_in_test), .rx_lock(rx_lock),
        .rx_frame_valid(rx_frame_valid), .rx_payload(rx_payload),
        .bc_link_detect(bc_link_detect));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Counts wake pulses and low pulses seen while checking
    always @(posedge ref_clk)
    begin
        pf_q <= pass_fail;
        if (bc_wake === 1'b1)
            wakes <= wakes + 1;
        if (pf_q === 1'b1 && pass_fail === 1'b0 && test_active === 1'b1)
            pulses <= pulses + 1;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task wr(input reg_addr_t a, input reg_data_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input reg_addr_t a, input reg_data_t e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait on the checking state; running out fails the run
    task wait_active(input logic want);
        int n;
        n = 0;
        while (test_active !== want && n < 400)
        begin
            idle(1);
            n++;
        end
        if (n == 400)
        begin
            failures++;
            print_verdict();
        end
    endtask

    initial
    begin
        {arst_n, en_pin, cs_pin, reg_wr, reg_rd} = '0;
        {clk_en, slow} = 2'b11;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        lfsr_q = 16'h003e;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(`OFS_CONFIG, `CONFIG_RESET);
        rd(`OFS_IRQ_MASK, 8'h00);
        rd(8'h40, 8'h00);
        chk(pass_fail, 8'h01);
        wr(`OFS_IRQ_MASK, 8'h07);
        wr(8'h40, 8'hff);
        rd(`OFS_CONFIG, 8'h00);
        // Test by pin; remote asleep and slow to wake
        @(posedge ref_clk);
        en_pin <= 1'b1;
        wait_active(1'b1);
        chk(8'(wakes), 8'h01);
        chk(pass_fail, 8'h01);
        chk(lock_status, 8'h01);
        rd(`OFS_LINK_DETECT, 8'h01);
        rd(`OFS_FWD_ERROR, 8'h00);
        rd(`OFS_IRQ_STATUS, 8'h01);
        wr(`OFS_IRQ_STATUS, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h00);
        chk(irq, 8'h00);
        // Errored frames: lowest bit, highest bit, then random masks
        for (int i = 0; i < 5; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            m = {lfsr_q, lfsr_q, lfsr_q[2:0]};
            m[lfsr_q % 35] = 1'b1;
            remote.send_err(i == 0 ? 35'h1 : i == 1 ? 35'h4_0000_0000 : m);
            idle(20);
        end
        chk(8'(pulses), 8'h05);
        rd(`OFS_FWD_ERROR, 8'h05);
        chk(irq, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h02);
        @(posedge ref_clk);
        en_pin <= 1'b0;
        wait_active(1'b0);
        idle(2);
        chk(pass_fail, 8'h00);
        chk(bc_test_enable, 8'h00);
        idle(40);
        chk(pass_fail, 8'h00);
        rd(`OFS_IRQ_STATUS, 8'h06);
        wr(`OFS_IRQ_MASK, 8'h00);
        idle(2);
        chk(irq, 8'h00);
        wr(`OFS_IRQ_STATUS, 8'h07);
        wr(`OFS_IRQ_MASK, 8'h07);
        idle(2);
        chk(irq, 8'h00);
        // Second test by config bit; remote already awake
        wr(`OFS_CONFIG, 8'h01);
        wait_active(1'b1);
        chk(8'(wakes), 8'h01);
        chk(pass_fail, 8'h01);
        rd(`OFS_FWD_ERROR, 8'h00);
        rd(`OFS_CONFIG, 8'h01);
        idle(60);
        wr(`OFS_CONFIG, 8'h00);
        wait_active(1'b0);
        idle(20);
        chk(pass_fail, 8'h01);
        // Oscillator choice by config bit, then by pin
        wr(`OFS_CONFIG, 8'h02);
        idle(2);
        chk(osc_select, 8'h01);
        rd(`OFS_CONFIG, 8'h02);
        wr(`OFS_CONFIG, 8'h00);
        idle(2);
        chk(osc_select, 8'h00);
        @(posedge ref_clk);
        cs_pin <= 1'b1;
        idle(6);
        chk(osc_select, 8'h01);
        // Frozen clock enable must hold the chosen source
        clk_en <= 1'b0;
        cs_pin <= 1'b0;
        idle(8);
        chk(osc_select, 8'h01);
        print_verdict();
    end
endmodule
